// file: hw/chan_if.sv
// Purpose: link between counter core and one compare channel
// Assumes: single clock domain
// Notes: core drives timing, channel returns its state
`timescale 1ns/10ps
interface chan_if;
  logic [15:0] count;
  logic tick;
  logic fast;
  logic clear_on_match_mode;
  logic top_hit;
  logic block;
  logic [15:0] fixed_mask;
  logic wr;
  logic [15:0] wdata;
  logic [1:0] out_mode;
  logic flag_clr;
  logic match;
  logic [15:0] active;
  logic [15:0] buffer;
  logic wave;
  logic flag;
  modport core (output count, tick, fast, clear_on_match_mode, top_hit, block, fixed_mask, wr, wdata, out_mode,
                flag_clr, input match, active, buffer, wave, flag);
  modport chan (input count, tick, fast, clear_on_match_mode, top_hit, block, fixed_mask, wr, wdata, out_mode,
                flag_clr, output match, active, buffer, wave, flag);
endinterface

// file: hw/compare_chan.sv
// Purpose: one compare channel: buffered compare value, match, flag, waveform state
// Assumes: core asserts top_hit only on a counting tick
// Notes: buffer always holds what software last wrote, masked by fixed_mask
`timescale 1ns/10ps
module compare_chan
  import timer16_pkg::*;
#(
  parameter bit TOGGLE_IN_FAST = 1'b0
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Core link
  chan_if.chan port
);
  typedef struct packed {
    logic [15:0] active;
    logic [15:0] buffer;
    logic wave;
    logic flag;
  } chan_state_t;

  chan_state_t st;
  chan_state_t next_st;
  logic match;
  logic [15:0] masked;

  assign port.match = match;
  assign port.active = st.active;
  assign port.buffer = st.buffer;
  assign port.wave = st.wave;
  assign port.flag = st.flag;

  always_comb
  begin
    next_st = st;
    match = port.tick && !port.block && (port.count == st.active);
    masked = port.wdata & port.fixed_mask;
    if (port.wr)
    begin
      next_st.buffer = masked;
      if (!port.fast)
        next_st.active = masked;
    end
    // Old buffer wins over a write in the same cycle
    if (port.fast && port.top_hit)
      next_st.active = st.buffer;
    if (port.clear_on_match_mode && match)
    begin
      case (out_mode_t'(port.out_mode))
        OUT_TOGGLE: next_st.wave = !st.wave;
        OUT_CLEAR: next_st.wave = 1'b0;
        OUT_SET: next_st.wave = 1'b1;
        default: next_st.wave = st.wave;
      endcase
    end
    else if (port.fast && match)
    begin
      // Match beats top so compare equal to top holds a level
      case (out_mode_t'(port.out_mode))
        OUT_TOGGLE: next_st.wave = TOGGLE_IN_FAST ? !st.wave : st.wave;
        OUT_CLEAR: next_st.wave = 1'b1;
        OUT_SET: next_st.wave = 1'b0;
        default: next_st.wave = st.wave;
      endcase
    end
    else if (port.fast && port.top_hit)
    begin
      case (out_mode_t'(port.out_mode))
        OUT_CLEAR: next_st.wave = 1'b0;
        OUT_SET: next_st.wave = 1'b1;
        default: next_st.wave = st.wave;
      endcase
    end
    next_st.flag = (st.flag && !port.flag_clr) || match;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st.active <= COMPARE_RESET;
      st.buffer <= COMPARE_RESET;
      st.wave <= WAVE_RESET;
      st.flag <= FLAG_RESET;
    end
    else
      st <= next_st;
  end
endmodule

// file: hw/timer16_pkg.sv
// Purpose: constants, types and mode decoding for the 16-bit waveform timer
// Assumes: counter advances only on the prescaled tick enable
// Notes: other mode codes are left to sibling logic
package timer16_pkg;
  localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
  localparam logic [3:0] MODE_FAST_8 = 4'h5;
  localparam logic [3:0] MODE_FAST_9 = 4'h6;
  localparam logic [3:0] MODE_FAST_10 = 4'h7;
  localparam logic [3:0] MODE_CTC_CAP = 4'hC;
  localparam logic [3:0] MODE_FAST_CAP = 4'hE;
  localparam logic [3:0] MODE_FAST_CMPA = 4'hF;
  localparam logic [15:0] TOP_FIXED_8 = 16'h00FF;
  localparam logic [15:0] TOP_FIXED_9 = 16'h01FF;
  localparam logic [15:0] TOP_FIXED_10 = 16'h03FF;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] FULL_MASK = 16'hFFFF;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
  localparam logic WAVE_RESET = 1'b0;
  localparam logic FLAG_RESET = 1'b0;

  typedef enum logic [1:0] {
    OUT_OFF = 2'b00,
    OUT_TOGGLE = 2'b01,
    OUT_CLEAR = 2'b10,
    OUT_SET = 2'b11
  } out_mode_t;

  function automatic logic mode_is_ctc(input logic [3:0] m);
    mode_is_ctc = (m == MODE_CTC_CMPA) || (m == MODE_CTC_CAP);
  endfunction

  function automatic logic mode_is_fast(input logic [3:0] m);
    mode_is_fast = (m == MODE_FAST_8) || (m == MODE_FAST_9) || (m == MODE_FAST_10) ||
                   (m == MODE_FAST_CAP) || (m == MODE_FAST_CMPA);
  endfunction

  // Fixed tops double as the write mask for compare values
  function automatic logic [15:0] mode_fixed_mask(input logic [3:0] m);
    case (m)
      MODE_FAST_8: mode_fixed_mask = TOP_FIXED_8;
      MODE_FAST_9: mode_fixed_mask = TOP_FIXED_9;
      MODE_FAST_10: mode_fixed_mask = TOP_FIXED_10;
      default: mode_fixed_mask = FULL_MASK;
    endcase
  endfunction

  function automatic logic [15:0] mode_top(input logic [3:0] m, input logic [15:0] cmpa,
                                           input logic [15:0] cap);
    case (m)
      MODE_CTC_CMPA, MODE_FAST_CMPA: mode_top = cmpa;
      MODE_CTC_CAP, MODE_FAST_CAP: mode_top = cap;
      default: mode_top = mode_fixed_mask(m);
    endcase
  endfunction
endpackage

// file: hw/timer16_wave.sv
// Purpose: 16-bit timer core for clear-on-match and single-slope fast PWM modes
// Assumes: i_tick is the one-cycle prescaler enable; writes are whole 16-bit words
// Notes: pin outputs lag the waveform state by one clock
`timescale 1ns/10ps
module timer16_wave
  import timer16_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Prescaled timer clock enable
  input wire logic i_tick,
  // Configuration
  input wire logic [3:0] i_waveform_mode_select,
  input wire logic [1:0] i_output_mode_a,
  input wire logic [1:0] i_output_mode_b,
  input wire logic i_pin_direction_a,
  input wire logic i_pin_direction_b,
  // Register writes
  input wire logic i_count_wr,
  input wire logic [15:0] i_count_wdata,
  input wire logic i_compare_a_wr,
  input wire logic [15:0] i_compare_a_wdata,
  input wire logic i_compare_b_wr,
  input wire logic [15:0] i_compare_b_wdata,
  input wire logic i_capture_top_wr,
  input wire logic [15:0] i_capture_top_wdata,
  // Flag clears
  input wire logic i_overflow_clr,
  input wire logic i_capture_clr,
  input wire logic i_compare_a_clr,
  input wire logic i_compare_b_clr,
  // Register readback
  output logic [15:0] o_count_value,
  output logic [15:0] o_compare_a_value,
  output logic [15:0] o_compare_b_value,
  output logic [15:0] o_capture_top_value,
  // Flags
  output logic o_overflow_flag,
  output logic o_capture_flag,
  output logic o_compare_a_flag,
  output logic o_compare_b_flag,
  // Waveform pins
  output logic o_wave_out_a,
  output logic o_wave_oe_a,
  output logic o_wave_out_b,
  output logic o_wave_oe_b,
  // Mode handled elsewhere
  output logic o_mode_foreign
);
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] capture_top;
    logic overflow;
    logic capture;
    logic block;
    logic [1:0] pin;
    logic [1:0] oe;
    logic foreign;
  } core_state_t;

  core_state_t st;
  core_state_t next_st;
  chan_if ch[2] ();

  logic clear_on_match_mode;
  logic fast;
  logic run;
  logic top_hit;
  logic [15:0] top;
  logic [1:0] wr;
  logic [1:0] clr;
  logic [1:0] dir;
  logic [15:0] wdata [2];
  logic [1:0] omode [2];
  logic [1:0] wave;
  logic [15:0] active_a;

  assign wr = {i_compare_b_wr, i_compare_a_wr};
  assign clr = {i_compare_b_clr, i_compare_a_clr};
  assign dir = {i_pin_direction_b, i_pin_direction_a};
  assign wdata[0] = i_compare_a_wdata;
  assign wdata[1] = i_compare_b_wdata;
  assign omode[0] = i_output_mode_a;
  assign omode[1] = i_output_mode_b;
  assign active_a = ch[0].active;

  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_chan
      assign ch[i].count = st.count;
      assign ch[i].tick = run;
      assign ch[i].fast = fast;
      assign ch[i].clear_on_match_mode = clear_on_match_mode;
      assign ch[i].top_hit = top_hit;
      assign ch[i].block = st.block;
      assign ch[i].fixed_mask = mode_fixed_mask(i_waveform_mode_select);
      assign ch[i].wr = wr[i];
      assign ch[i].wdata = wdata[i];
      assign ch[i].out_mode = omode[i];
      assign ch[i].flag_clr = clr[i];
      assign wave[i] = ch[i].wave;
      // Only channel A has the toggle action in fast PWM
      compare_chan #(
        .TOGGLE_IN_FAST(i == 0)
      ) u_chan (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .port(ch[i].chan)
      );
    end
  endgenerate

  always_comb
  begin
    next_st = st;
    clear_on_match_mode = mode_is_ctc(i_waveform_mode_select);
    fast = mode_is_fast(i_waveform_mode_select);
    top = mode_top(i_waveform_mode_select, active_a, st.capture_top);
    run = i_tick && (clear_on_match_mode || fast);
    // A count write blocks the top match on the next tick too
    top_hit = run && !st.block && (st.count == top);
    next_st.foreign = !(clear_on_match_mode || fast);

    if (i_capture_top_wr)
      next_st.capture_top = i_capture_top_wdata;

    if (i_count_wr)
      next_st.block = 1'b1;
    else if (i_tick)
      next_st.block = 1'b0;

    if (i_count_wr)
      next_st.count = i_count_wdata;
    else if (top_hit)
      next_st.count = COUNT_BOTTOM;
    else if (run)
      next_st.count = st.count + 16'h0001;

    // Top match is an equality test only, so a late top wraps through MAX
    next_st.overflow = (st.overflow && !i_overflow_clr) ||
                       (clear_on_match_mode && run && st.count == COUNT_MAX) ||
                       (fast && top_hit);

    next_st.capture = (st.capture && !i_capture_clr) ||
                      (top_hit && (i_waveform_mode_select == MODE_CTC_CAP ||
                                   i_waveform_mode_select == MODE_FAST_CAP));

    for (int i = 0; i < 2; i++)
    begin
      next_st.oe[i] = dir[i];
      next_st.pin[i] = dir[i] && wave[i];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st.count <= COUNT_BOTTOM;
      st.capture_top <= CAPTURE_RESET;
      st.overflow <= FLAG_RESET;
      st.capture <= FLAG_RESET;
      st.block <= 1'b0;
      st.pin <= 2'b00;
      st.oe <= 2'b00;
      st.foreign <= 1'b0;
    end
    else
      st <= next_st;
  end

  assign o_count_value = st.count;
  assign o_compare_a_value = ch[0].buffer;
  assign o_compare_b_value = ch[1].buffer;
  assign o_capture_top_value = st.capture_top;
  assign o_overflow_flag = st.overflow;
  assign o_capture_flag = st.capture;
  assign o_compare_a_flag = ch[0].flag;
  assign o_compare_b_flag = ch[1].flag;
  assign o_wave_out_a = st.pin[0];
  assign o_wave_oe_a = st.oe[0];
  assign o_wave_out_b = st.pin[1];
  assign o_wave_oe_b = st.oe[1];
  assign o_mode_foreign = st.foreign;

  // Checks
  sequence s_fast_top;
    fast && top_hit && !i_count_wr;
  endsequence

  sequence s_wrapped;
    (st.count == COUNT_BOTTOM) && st.overflow;
  endsequence

  property p_ctc_clear;
    @(posedge i_clk) disable iff (i_rst)
    (clear_on_match_mode && top_hit && !i_count_wr) |=> (st.count == COUNT_BOTTOM);
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("CLEAR_ON_MATCH_MODE counter not cleared at top");

  property p_ctc_flag;
    @(posedge i_clk) disable iff (i_rst)
    (top_hit && i_waveform_mode_select == MODE_CTC_CMPA) |=> o_compare_a_flag;
  endproperty
  a_ctc_flag: assert property (p_ctc_flag) else $error("Compare A flag missing at CLEAR_ON_MATCH_MODE top");

  property p_ctc_overflow;
    @(posedge i_clk) disable iff (i_rst)
    (clear_on_match_mode && run && st.count == COUNT_MAX) |=> o_overflow_flag;
  endproperty
  a_ctc_overflow: assert property (p_ctc_overflow) else $error("Overflow not set at MAX");

  property p_fast_wrap;
    @(posedge i_clk) disable iff (i_rst)
    s_fast_top |=> s_wrapped;
  endproperty
  a_fast_wrap: assert property (p_fast_wrap) else $error("Fast PWM top did not clear and flag");

  property p_fast_load;
    @(posedge i_clk) disable iff (i_rst)
    s_fast_top |=> (active_a == $past(ch[0].buffer));
  endproperty
  a_fast_load: assert property (p_fast_load) else $error("Compare A not loaded at top");

  property p_fast_buffered;
    @(posedge i_clk) disable iff (i_rst)
    (fast && !top_hit && $stable(i_waveform_mode_select)) |=> $stable(active_a);
  endproperty
  a_fast_buffered: assert property (p_fast_buffered) else $error("Active compare moved mid-period");

  property p_count_up;
    @(posedge i_clk) disable iff (i_rst)
    (run && !top_hit && !i_count_wr) |=> (st.count == $past(st.count) + 16'h0001);
  endproperty
  a_count_up: assert property (p_count_up) else $error("Counter did not advance by one");

  property p_hold;
    @(posedge i_clk) disable iff (i_rst)
    (!i_tick && !i_count_wr) |=> $stable(st.count);
  endproperty
  a_hold: assert property (p_hold) else $error("Counter moved without a tick");

  property p_mask;
    @(posedge i_clk) disable iff (i_rst)
    (i_compare_b_wr && i_waveform_mode_select == MODE_FAST_8) |=>
      ((o_compare_b_value & ~TOP_FIXED_8) == 16'h0000);
  endproperty
  a_mask: assert property (p_mask) else $error("Compare bits above resolution kept");

  property p_pin_off;
    @(posedge i_clk) disable iff (i_rst)
    !i_pin_direction_a |=> (!o_wave_out_a && !o_wave_oe_a);
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("Pin A driven while input");

  property p_ctc_toggle;
    @(posedge i_clk) disable iff (i_rst)
    (clear_on_match_mode && ch[0].match && i_output_mode_a == OUT_TOGGLE) |=> (ch[0].wave != $past(ch[0].wave));
  endproperty
  a_ctc_toggle: assert property (p_ctc_toggle) else $error("Output A did not toggle on match");

  property p_noninv_top;
    @(posedge i_clk) disable iff (i_rst)
    (s_fast_top and (!ch[1].match && i_output_mode_b == OUT_CLEAR)) |=> !ch[1].wave;
  endproperty
  a_noninv_top: assert property (p_noninv_top) else $error("Non-inverted B not cleared at top");

  property p_off_hold;
    @(posedge i_clk) disable iff (i_rst)
    (i_output_mode_b == OUT_OFF && $stable(i_output_mode_b)) |=> $stable(ch[1].wave);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("Output B changed with mode off");

  property p_foreign;
    @(posedge i_clk) disable iff (i_rst)
    (!(clear_on_match_mode || fast) && !i_count_wr) |=> ($stable(st.count) && o_mode_foreign);
  endproperty
  a_foreign: assert property (p_foreign) else $error("Block acted in a foreign mode");

  sequence s_cap_top;
    top_hit && (i_waveform_mode_select == MODE_CTC_CAP || i_waveform_mode_select == MODE_FAST_CAP);
  endsequence

  property p_cap_flag;
    @(posedge i_clk) disable iff (i_rst)
    s_cap_top |=> o_capture_flag;
  endproperty
  a_cap_flag: assert property (p_cap_flag) else $error("Capture flag missing at top");

  property p_fast_flag_a;
    @(posedge i_clk) disable iff (i_rst)
    (s_fast_top ##0 (i_waveform_mode_select == MODE_FAST_CMPA)) |=> (o_compare_a_flag && o_overflow_flag);
  endproperty
  a_fast_flag_a: assert property (p_fast_flag_a) else $error("Flags missing at fast top");

  property p_oe_b;
    @(posedge i_clk) disable iff (i_rst)
    1'b1 |=> (o_wave_oe_b == $past(i_pin_direction_b));
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("Pin B enable off direction");

  property p_pin_b;
    @(posedge i_clk) disable iff (i_rst)
    i_pin_direction_b |=> (o_wave_out_b == $past(ch[1].wave));
  endproperty
  a_pin_b: assert property (p_pin_b) else $error("Pin B does not show waveform");

  property p_flag_b;
    @(posedge i_clk) disable iff (i_rst)
    ch[1].match |=> o_compare_b_flag;
  endproperty
  a_flag_b: assert property (p_flag_b) else $error("Compare B flag missing");

  property p_noninv_match;
    @(posedge i_clk) disable iff (i_rst)
    (fast && ch[1].match && i_output_mode_b == OUT_CLEAR) |=> ch[1].wave;
  endproperty
  a_noninv_match: assert property (p_noninv_match) else $error("Non-inverted B not set");

  property p_inv_match;
    @(posedge i_clk) disable iff (i_rst)
    (fast && ch[1].match && i_output_mode_b == OUT_SET) |=> !ch[1].wave;
  endproperty
  a_inv_match: assert property (p_inv_match) else $error("Inverted B not cleared");

  property p_inv_top;
    @(posedge i_clk) disable iff (i_rst)
    (fast && top_hit && !ch[1].match && i_output_mode_b == OUT_SET) |=> ch[1].wave;
  endproperty
  a_inv_top: assert property (p_inv_top) else $error("Inverted B not set at top");

  property p_ctc_direct;
    @(posedge i_clk) disable iff (i_rst)
    (clear_on_match_mode && i_compare_b_wr) |=> (ch[1].active == $past(i_compare_b_wdata));
  endproperty
  a_ctc_direct: assert property (p_ctc_direct) else $error("Compare B write not direct");

  property p_mask_wide;
    @(posedge i_clk) disable iff (i_rst)
    (i_compare_b_wr && (i_waveform_mode_select == MODE_FAST_9 || i_waveform_mode_select == MODE_FAST_10)) |=>
      ((o_compare_b_value & ~TOP_FIXED_10) == 16'h0000);
  endproperty
  a_mask_wide: assert property (p_mask_wide) else $error("Compare B high bits kept");

  property p_fast_toggle;
    @(posedge i_clk) disable iff (i_rst)
    (fast && ch[0].match && i_output_mode_a == OUT_TOGGLE) |=> (ch[0].wave != $past(ch[0].wave));
  endproperty
  a_fast_toggle: assert property (p_fast_toggle) else $error("Output A did not toggle");
endmodule

// file: verification/tb_top.sv
// Purpose: self-checking bench for the 16-bit waveform timer core
// Assumes: tick held high while counting, so one count per clock
// Notes: inputs move 10 ns after each rising edge; pins lag state by one clock
`timescale 1ns/10ps
`define CHECK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
  $display("BAD %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
  import timer16_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_tick = 1'b0;
  logic [3:0] i_waveform_mode_select = 4'h0;
  logic [1:0] i_output_mode_a = 2'h0;
  logic [1:0] i_output_mode_b = 2'h0;
  logic i_pin_direction_a = 1'b1;
  logic i_pin_direction_b = 1'b1;
  logic i_count_wr = 1'b0;
  logic [15:0] i_count_wdata = 16'h0000;
  logic i_compare_a_wr = 1'b0;
  logic [15:0] i_compare_a_wdata = 16'h0000;
  logic i_compare_b_wr = 1'b0;
  logic [15:0] i_compare_b_wdata = 16'h0000;
  logic i_capture_top_wr = 1'b0;
  logic [15:0] i_capture_top_wdata = 16'h0000;
  logic i_overflow_clr = 1'b0;
  logic i_capture_clr = 1'b0;
  logic i_compare_a_clr = 1'b0;
  logic i_compare_b_clr = 1'b0;
  logic [15:0] o_count_value;
  logic [15:0] o_compare_a_value;
  logic [15:0] o_compare_b_value;
  logic [15:0] o_capture_top_value;
  logic o_overflow_flag;
  logic o_capture_flag;
  logic o_compare_a_flag;
  logic o_compare_b_flag;
  logic o_wave_out_a;
  logic o_wave_oe_a;
  logic o_wave_out_b;
  logic o_wave_oe_b;
  logic o_mode_foreign;
  int error_cnt = 0;
  int compares = 0;
  logic keep;

  timer16_wave timer16_wave_inst (.i_clk(i_clk), .i_rst(i_rst), .i_tick(i_tick),
    .i_waveform_mode_select(i_waveform_mode_select), .i_output_mode_a(i_output_mode_a),
    .i_output_mode_b(i_output_mode_b), .i_pin_direction_a(i_pin_direction_a),
    .i_pin_direction_b(i_pin_direction_b), .i_count_wr(i_count_wr), .i_count_wdata(i_count_wdata),
    .i_compare_a_wr(i_compare_a_wr), .i_compare_a_wdata(i_compare_a_wdata),
    .i_compare_b_wr(i_compare_b_wr), .i_compare_b_wdata(i_compare_b_wdata),
    .i_capture_top_wr(i_capture_top_wr), .i_capture_top_wdata(i_capture_top_wdata),
    .i_overflow_clr(i_overflow_clr), .i_capture_clr(i_capture_clr), .i_compare_a_clr(i_compare_a_clr),
    .i_compare_b_clr(i_compare_b_clr), .o_count_value(o_count_value),
    .o_compare_a_value(o_compare_a_value), .o_compare_b_value(o_compare_b_value),
    .o_capture_top_value(o_capture_top_value), .o_overflow_flag(o_overflow_flag),
    .o_capture_flag(o_capture_flag), .o_compare_a_flag(o_compare_a_flag),
    .o_compare_b_flag(o_compare_b_flag), .o_wave_out_a(o_wave_out_a), .o_wave_oe_a(o_wave_oe_a),
    .o_wave_out_b(o_wave_out_b), .o_wave_oe_b(o_wave_oe_b), .o_mode_foreign(o_mode_foreign));

  initial
  begin
    forever #50 i_clk = ~i_clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #10;
  endtask

  // One-cycle write strobe; 0 count, 1 compare A, 2 compare B, 3 capture-top
  task automatic wr(input int sel, input logic [15:0] d);
    case (sel)
      0: begin i_count_wr = 1'b1; i_count_wdata = d; end
      1: begin i_compare_a_wr = 1'b1; i_compare_a_wdata = d; end
      2: begin i_compare_b_wr = 1'b1; i_compare_b_wdata = d; end
      default: begin i_capture_top_wr = 1'b1; i_capture_top_wdata = d; end
    endcase
    step(1);
    {i_count_wr, i_compare_a_wr, i_compare_b_wr, i_capture_top_wr} = 4'h0;
  endtask

  task automatic clr_flags();
    {i_overflow_clr, i_capture_clr, i_compare_a_clr, i_compare_b_clr} = 4'hF;
    step(1);
    {i_overflow_clr, i_capture_clr, i_compare_a_clr, i_compare_b_clr} = 4'h0;
    step(1);
  endtask

  // Bounded wait; a stuck counter is reported, not hung on
  task automatic wait_cnt(input logic [15:0] v);
    int n;
    n = 0;
    while (o_count_value !== v && n < 600)
    begin
      step(1);
      n++;
    end
    if (n >= 600)
    begin
      error_cnt++;
      $display("BAD wait_cnt expected %0h seen %0h", v, o_count_value);
    end
  endtask

  task automatic t_reset();
    step(3);
    `CHECK("reset_outs", 73'h0, {o_count_value, o_compare_a_value, o_compare_b_value,
      o_capture_top_value, o_overflow_flag, o_capture_flag, o_compare_a_flag, o_compare_b_flag,
      o_wave_out_a, o_wave_oe_a, o_wave_out_b, o_wave_oe_b, o_mode_foreign})
    step(3);
    i_rst = 1'b0;
  endtask

  task automatic t_ctc_a();
    i_waveform_mode_select = MODE_CTC_CMPA;
    i_output_mode_a = OUT_TOGGLE;
    wr(1, 16'h0003);
    step(1);
    `CHECK("cmpa_rb", 16'h0003, o_compare_a_value)
    clr_flags();
    i_tick = 1'b1;
    wait_cnt(16'h0003);
    step(1);
    `CHECK("ctc_clear", 16'h0000, o_count_value)
    `CHECK("ctc_flag_a", 1'b1, o_compare_a_flag)
    step(1);
    `CHECK("ctc_tog1", 1'b1, o_wave_out_a)
    step(4);
    `CHECK("ctc_tog2", 1'b0, o_wave_out_a)
  endtask

  // Top written below the count: run on through 0xFFFF before matching
  task automatic t_ctc_wrap();
    i_tick = 1'b0;
    i_waveform_mode_select = MODE_CTC_CAP;
    wr(0, 16'hFFF0);
    wr(3, 16'h0008);
    clr_flags();
    i_tick = 1'b1;
    wait_cnt(16'hFFFF);
    step(1);
    `CHECK("wrap_cnt", 16'h0000, o_count_value)
    `CHECK("ovf_flag", 1'b1, o_overflow_flag)
    `CHECK("cap_early", 1'b0, o_capture_flag)
    wait_cnt(16'h0008);
    `CHECK("cmpa_flag", 1'b1, o_compare_a_flag)
    step(1);
    `CHECK("cap_clear", 16'h0000, o_count_value)
    `CHECK("cap_flag", 1'b1, o_capture_flag)
  endtask

  task automatic t_fast_cmpa();
    i_tick = 1'b0;
    i_waveform_mode_select = MODE_CTC_CMPA;
    wr(2, 16'h0002);
    wr(1, 16'h0003);
    wr(0, 16'h0000);
    i_waveform_mode_select = MODE_FAST_CMPA;
    i_output_mode_b = OUT_CLEAR;
    wr(1, 16'h0007);
    step(1);
    `CHECK("buf_rb", 16'h0007, o_compare_a_value)
    clr_flags();
    i_tick = 1'b1;
    wait_cnt(16'h0003);
    step(1);
    `CHECK("old_top", 16'h0000, o_count_value)
    `CHECK("f_ovf", 1'b1, o_overflow_flag)
    `CHECK("f_flag_a", 1'b1, o_compare_a_flag)
    for (int p = 0; p < 2; p++)
    begin
      i_output_mode_b = p ? OUT_SET : OUT_CLEAR;
      wait_cnt(16'h0002);
      step(2);
      `CHECK("pwm_match", ~p[0], o_wave_out_b)
      wait_cnt(16'h0007);
      step(1);
      `CHECK("new_top", 16'h0000, o_count_value)
      step(1);
      `CHECK("pwm_top", p[0], o_wave_out_b)
    end
    keep = o_wave_out_a;
    step(8);
    `CHECK("fast_tog", ~keep, o_wave_out_a)
    i_output_mode_b = OUT_CLEAR;
    wr(2, 16'h0007);
    wait_cnt(16'h0007);
    step(1);
    wait_cnt(16'h0007);
    step(2);
    for (int k = 0; k < 8; k++)
    begin
      `CHECK("cmp_eq_top", 1'b1, o_wave_out_b)
      step(1);
    end
  endtask

  task automatic t_fixed();
    logic [15:0] top;
    for (int i = 0; i < 3; i++)
    begin
      top = (i == 0) ? 16'h00FF : (i == 1) ? 16'h01FF : 16'h03FF;
      i_tick = 1'b0;
      i_waveform_mode_select = MODE_FAST_8 + i[3:0];
      wr(2, 16'hFFFF);
      step(1);
      `CHECK("mask_rb", top, o_compare_b_value)
      wr(0, top - 16'h0002);
      clr_flags();
      i_tick = 1'b1;
      wait_cnt(top);
      step(1);
      `CHECK("fix_top", 16'h0000, o_count_value)
      `CHECK("fix_ovf", 1'b1, o_overflow_flag)
    end
  endtask

  // Capture-top written below the count: no flags until the real top
  task automatic t_fast_cap();
    i_tick = 1'b0;
    i_waveform_mode_select = MODE_FAST_CAP;
    wr(3, 16'h0005);
    `CHECK("cap_rb", 16'h0005, o_capture_top_value)
    wr(2, 16'h0002);
    wr(0, 16'hFFFC);
    clr_flags();
    i_tick = 1'b1;
    wait_cnt(16'h0000);
    `CHECK("late_ovf", 1'b0, o_overflow_flag)
    `CHECK("late_cap", 1'b0, o_capture_flag)
    wait_cnt(16'h0005);
    step(1);
    `CHECK("cap_top", 16'h0000, o_count_value)
    `CHECK("cap_ovf", 1'b1, o_overflow_flag)
    `CHECK("cap_flag_f", 1'b1, o_capture_flag)
    `CHECK("b_buffered", 1'b0, o_compare_b_flag)
    wait_cnt(16'h0003);
    `CHECK("b_flag", 1'b1, o_compare_b_flag)
    `CHECK("oe_b", 1'b1, o_wave_oe_b)
  endtask

  task automatic t_idle();
    i_waveform_mode_select = MODE_CTC_CMPA;
    i_tick = 1'b0;
    step(1);
    keep = o_count_value[0];
    step(3);
    `CHECK("no_tick", keep, o_count_value[0])
    i_waveform_mode_select = 4'h0;
    i_tick = 1'b1;
    step(2);
    `CHECK("foreign", 1'b1, o_mode_foreign)
    keep = o_count_value[0];
    step(3);
    `CHECK("frozen", keep, o_count_value[0])
    i_pin_direction_a = 1'b0;
    step(2);
    `CHECK("pin_off", 2'b00, {o_wave_out_a, o_wave_oe_a})
  endtask

  task automatic wrap_up();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    step(0);
    t_reset();
    t_ctc_a();
    t_ctc_wrap();
    t_fast_cmpa();
    t_fixed();
    t_fast_cap();
    t_idle();
    wrap_up();
  end
endmodule
